// file: common/reg_wr_if.sv
`timescale 1ns/10ps
interface reg_wr_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    modport master (output wr_en, output addr, output wdata);
    modport slave (input wr_en, input addr, input wdata);
endinterface

// file: common/slot_pwr_pkg.sv
package slot_pwr_pkg;
    // Register width and command byte values
    localparam int REG_W = 8;
    localparam logic [7:0] ADDR_CTRL_A = 8'h02;
    localparam logic [7:0] ADDR_CTRL_B = 8'h03;
    localparam logic [7:0] ADDR_STAT_A = 8'h04;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Control register layout
    localparam int CTRL_AUX_GOOD_BIT = 7;
    localparam int CTRL_MAIN_GOOD_BIT = 6;
    localparam int CTRL_RSV_MSB = 5;
    localparam int CTRL_RSV_LSB = 3;
    localparam int CTRL_GATE_BIT = 2;
    localparam int CTRL_MAIN_EN_BIT = 1;
    localparam int CTRL_AUX_EN_BIT = 0;
    localparam logic [2:0] CTRL_RSV_ZERO = 3'h0;

    // Status register layout
    localparam int STAT_FAULT_BIT = 7;
    localparam int STAT_MAIN_ON_BIT = 6;
    localparam int STAT_AUX_ON_BIT = 5;
    localparam int STAT_AUX_OC_BIT = 4;
    localparam int STAT_HIGH_OC_BIT = 2;
    localparam int STAT_LOW_OC_BIT = 0;
    localparam logic STAT_RSV_ZERO = 1'b0;

    // Overcurrent flag vector order
    localparam int OC_W = 3;
    localparam int OC_AUX = 2;
    localparam int OC_HIGH = 1;
    localparam int OC_LOW = 0;
    localparam logic [2:0] OC_NONE = 3'h0;
endpackage

// file: dv/host_model.sv
`timescale 1ns/10ps
// Register host: one-cycle strobes, launched on the falling edge
module host_model (
    input wire logic clk_sys_i, // System clock
    output logic [7:0] addr_o,  // Command byte
    output logic wr_o,          // Write strobe
    output logic [7:0] wdata_o, // Write data
    output logic rd_o           // Read strobe
);
    // Idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Released bus shows inverted last value, so stale data never matches
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_sys_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask

    // Read strobe for exactly one sampling edge
    task automatic rd_reg(input logic [7:0] a);
        @(negedge clk_sys_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_sys_i);
        rd_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule // host_model

// file: dv/tb.sv
`timescale 1ns/10ps
module tb
    import slot_pwr_pkg::*;
;
    logic clk_sys_i, nrst_i, wr, rd, rd_pend;
    logic [7:0] addr, wdata, rdata, d, e;
    logic ag_a, mg_a, ag_b, mg_b, ov_a_n, ov_b_n, mreq_a, areq_a;
    logic [2:0] oc;
    logic mon_a, aon_a, mon_b, aon_b, pgd_a, pg_a_n, pgd_b, pg_b_n, fd_a, flt_n, int_n;
    logic [7:0] exp_q[$];
    int fails, checks, seed, i, j;

    host_model i_host_model (.clk_sys_i(clk_sys_i), .addr_o(addr), .wr_o(wr),
        .wdata_o(wdata), .rd_o(rd));

    slot_power_control_status_regs i_slot_power_control_status_regs (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .aux_good_a_i(ag_a), .main_good_a_i(mg_a), .aux_good_b_i(ag_b),
        .main_good_b_i(mg_b), .override_on_a_n_i(ov_a_n), .override_on_b_n_i(ov_b_n),
        .main_request_a_i(mreq_a), .aux_request_a_i(areq_a),
        .aux_overcurrent_a_i(oc[OC_AUX]), .high_rail_overcurrent_a_i(oc[OC_HIGH]),
        .low_rail_overcurrent_a_i(oc[OC_LOW]), .main_on_a_o(mon_a), .aux_on_a_o(aon_a),
        .main_on_b_o(mon_b), .aux_on_b_o(aon_b), .power_good_out_a_n_o(pgd_a),
        .power_good_a_oe_n_o(pg_a_n), .power_good_out_b_n_o(pgd_b),
        .power_good_b_oe_n_o(pg_b_n), .fault_out_a_n_o(fd_a), .fault_a_oe_n_o(flt_n),
        .int_n_o(int_n));

    // System clock, 100 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expectation is queued before the strobe so the monitor never races it
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        i_host_model.rd_reg(a);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Monitor: read data lands one edge after the strobe, compared mid-cycle
    always @(posedge clk_sys_i) rd_pend <= rd;
    always @(negedge clk_sys_i) begin
        if (rd_pend === 1'b1) begin
            if (exp_q.size() > 0)
                check(rdata, exp_q.pop_front());
            else
                check(rdata, 8'hxx);
        end
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        fails++;
        finish_test();
    end

    initial begin
        seed = 36591;
        fails = 0;
        checks = 0;
        nrst_i = 1'b0;
        {ag_a, mg_a, ag_b, mg_b, mreq_a, areq_a} = 6'h00;
        {ov_a_n, ov_b_n} = 2'h3;
        oc = OC_NONE;
        cyc(3);
        nrst_i = 1'b1;

        // Reset state, then unmapped addresses
        check({mon_a, aon_a, mon_b, aon_b, pg_a_n, pg_b_n, flt_n, int_n}, 8'h0f);
        check({5'h0, pgd_a, pgd_b, fd_a}, 8'h00);
        rd_exp(ADDR_CTRL_A, REG_RESET);
        rd_exp(ADDR_CTRL_B, REG_RESET);
        rd_exp(ADDR_STAT_A, REG_RESET);
        i_host_model.wr_reg(8'h05, 8'hff);
        i_host_model.wr_reg(8'hff, 8'hff);
        rd_exp(8'h05, RD_UNMAPPED);
        rd_exp(8'hff, RD_UNMAPPED);
        rd_exp(ADDR_CTRL_A, REG_RESET);
        check({4'h0, mon_a, aon_a, mon_b, aon_b}, 8'h00);
        $display("TEST reset done");

        // Random control writes to both slots, readback of live good bits
        for (i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            j = $random(seed);
            ag_a = j[0];
            mg_a = j[1];
            ag_b = j[2];
            mg_b = j[3];
            addr_pick(i[0]);
        end
        $display("TEST control done");

        // Power-good pin against every good, override and gate combination
        for (i = 0; i < 32; i++) begin
            ag_a = i[0];
            ag_b = i[0];
            mg_a = i[1];
            mg_b = i[1];
            ov_a_n = i[2];
            ov_b_n = i[2];
            e = i[4] ? ADDR_CTRL_B : ADDR_CTRL_A;
            i_host_model.wr_reg(e, {5'h0, i[3], 2'b00});
            cyc(1);
            d = {7'h0, ~(i[0] & i[1] & ~(~i[2] & ~i[3]))};
            check({7'h0, i[4] ? pg_b_n : pg_a_n}, d);
            rd_exp(e, {i[0], i[1], CTRL_RSV_ZERO, i[3], 2'b00});
        end
        $display("TEST power good done");

        // Sticky flags under register control; request pins stay low
        ov_a_n = 1'b1;
        i_host_model.wr_reg(ADDR_CTRL_A, 8'h03);
        for (i = 0; i < 3; i++) begin
            d = 8'h01 << (2 * i);
            oc[i] = 1'b1;
            cyc(1);
            oc = OC_NONE;
            cyc(1);
            check({7'h0, int_n}, 8'h00);
            check({7'h0, flt_n}, 8'h01);
            rd_exp(ADDR_STAT_A, 8'h60 | d);
            i_host_model.wr_reg(ADDR_STAT_A, ~d);
            rd_exp(ADDR_STAT_A, 8'h60 | d);
            check({7'h0, int_n}, 8'h00);
            i_host_model.wr_reg(ADDR_STAT_A, d);
            cyc(1);
            check({7'h0, int_n}, 8'h01);
            rd_exp(ADDR_STAT_A, 8'h60);
        end
        $display("TEST overcurrent done");

        // Pin-driven paths: trip, clear flag, fault holds until request drops
        i_host_model.wr_reg(ADDR_CTRL_A, 8'h00);
        for (i = 0; i < 2; i++) begin
            mreq_a = (i == 0);
            areq_a = (i == 1);
            e = i[0] ? 8'h10 : 8'h04;
            cyc(2);
            check({6'h0, mon_a, aon_a}, i[0] ? 8'h01 : 8'h02);
            oc = i[0] ? 3'h4 : 3'h2;
            cyc(1);
            oc = OC_NONE;
            cyc(1);
            check({7'h0, flt_n}, 8'h00);
            rd_exp(ADDR_STAT_A, 8'h80 | e);
            i_host_model.wr_reg(ADDR_STAT_A, e);
            rd_exp(ADDR_STAT_A, 8'h80);
            check({7'h0, flt_n}, 8'h00);
            mreq_a = 1'b0;
            areq_a = 1'b0;
            cyc(2);
            check({7'h0, flt_n}, 8'h01);
            rd_exp(ADDR_STAT_A, 8'h00);
        end
        $display("TEST fault done");
        cyc(2);
        finish_test();
    end

    // Write one slot's control byte, then check outputs and readback
    task automatic addr_pick(input logic s);
        e = s ? ADDR_CTRL_B : ADDR_CTRL_A;
        i_host_model.wr_reg(e, d);
        cyc(1);
        check({6'h0, s ? {mon_b, aon_b} : {mon_a, aon_a}}, {6'h0, d[1:0]});
        d = {s ? {ag_b, mg_b} : {ag_a, mg_a}, CTRL_RSV_ZERO, d[2:0]};
        rd_exp(e, d);
    endtask
endmodule // tb

// file: logic/ovc_flags.sv
`timescale 1ns/10ps
module ovc_flags
    import slot_pwr_pkg::*;
#(
    parameter logic [7:0] REG_ADDR = ADDR_STAT_A
) (
    input wire logic clk_sys_i,       // System clock
    input wire logic nrst_i,          // Sync reset, active low
    reg_wr_if.slave bus,              // Register write port
    input wire logic [OC_W-1:0] oc_i, // Overcurrent events
    output logic [OC_W-1:0] flags_o   // Sticky flags
);
    logic [OC_W-1:0] flags_ff;

    // Write-one-to-clear; a new event in the same cycle wins
    wire logic hit = bus.wr_en && (bus.addr == REG_ADDR);
    wire logic [OC_W-1:0] wr_bits = {bus.wdata[STAT_AUX_OC_BIT], bus.wdata[STAT_HIGH_OC_BIT],
                                     bus.wdata[STAT_LOW_OC_BIT]};
    wire logic [OC_W-1:0] clr = hit ? wr_bits : OC_NONE;
    wire logic [OC_W-1:0] nxt_flags = (flags_ff & ~clr) | oc_i;

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            flags_ff <= OC_NONE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags_o = flags_ff;
endmodule // ovc_flags

// file: logic/slot_ctrl_reg.sv
`timescale 1ns/10ps
module slot_ctrl_reg
    import slot_pwr_pkg::*;
#(
    parameter logic [7:0] REG_ADDR = ADDR_CTRL_A
) (
    input wire logic clk_sys_i,    // System clock
    input wire logic nrst_i,       // Sync reset, active low
    reg_wr_if.slave bus,           // Register write port
    input wire logic aux_good_i,   // Aux rail above lockout
    input wire logic main_good_i,  // Main rails above lockout
    input wire logic override_n_i, // Force-override, active low
    input wire logic main_req_i,   // Main-on pin
    input wire logic aux_req_i,    // Aux-enable pin
    input wire logic main_trip_i,  // Main breaker tripped
    input wire logic aux_trip_i,   // Aux breaker tripped
    output logic [7:0] ctrl_rd_o,  // Readback value
    output logic main_on_o,        // Main outputs on
    output logic aux_on_o,         // Aux output on
    output logic pg_oe_n_o         // Power-good pin enable, low drives
);
    logic [CTRL_GATE_BIT:0] ctrl_ff;
    logic main_on_ff;
    logic aux_on_ff;
    logic pg_oe_n_ff;

    // Decode; only the low three bits are storage
    wire logic hit = bus.wr_en && (bus.addr == REG_ADDR);
    wire logic pg_forced = !override_n_i && !ctrl_ff[CTRL_GATE_BIT];
    wire logic pg_true = aux_good_i && main_good_i;
    wire logic nxt_main_on = ctrl_ff[CTRL_MAIN_EN_BIT] || (main_req_i && !main_trip_i);
    wire logic nxt_aux_on = ctrl_ff[CTRL_AUX_EN_BIT] || (aux_req_i && !aux_trip_i);
    wire logic nxt_pg_oe_n = !(pg_true && !pg_forced);

    // Writable bits; read-only positions are never stored
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ctrl_ff <= REG_RESET[CTRL_GATE_BIT:0];
        end else if (hit) begin
            ctrl_ff <= bus.wdata[CTRL_GATE_BIT:0];
        end
    end

    // Registered pin drive; reset leaves everything off and released
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            main_on_ff <= 1'b0;
            aux_on_ff <= 1'b0;
            pg_oe_n_ff <= 1'b1;
        end else begin
            main_on_ff <= nxt_main_on;
            aux_on_ff <= nxt_aux_on;
            pg_oe_n_ff <= nxt_pg_oe_n;
        end
    end

    // Good bits show the rails even while override is forcing the pin
    assign ctrl_rd_o = {aux_good_i, main_good_i, CTRL_RSV_ZERO, ctrl_ff};
    assign main_on_o = main_on_ff;
    assign aux_on_o = aux_on_ff;
    assign pg_oe_n_o = pg_oe_n_ff;
endmodule // slot_ctrl_reg

// file: logic/slot_power_control_status_regs.sv
// Summary of operation
// - Control bit 7 reads aux power-good
// - Control bit 6 reads main power-good
// - Control bit 2 gates force-override input
// - Control bit 1 switches main outputs
// - Control bit 0 switches aux output
// - All registers zero at reset, outputs off
// - Power-good pin is AND of good bits
// - Active override forces power-good released
// - Good bits ignore the override input
// - Status bit 7 mirrors fault pin low
// - Status bit 6 shows main outputs state
// - Status bit 5 shows aux output state
// - Overcurrent sets status bits 4, 2, 0
// - Write one clears flag, drops interrupt
// - Status access leaves fault pin alone
// - Slot B control mirrors slot A
// - Fault cleared by matching request pin low
// - Register-driven paths keep fault inactive
`timescale 1ns/10ps
module slot_power_control_status_regs
    import slot_pwr_pkg::*;
(
    input wire logic clk_sys_i,                 // System clock, 100 MHz
    input wire logic nrst_i,                    // Sync reset, active low
    input wire logic [REG_W-1:0] reg_addr_i,    // Command byte
    input wire logic reg_wr_i,                  // Write strobe
    input wire logic [REG_W-1:0] reg_wdata_i,   // Write data
    input wire logic reg_rd_i,                  // Read strobe
    output logic [REG_W-1:0] reg_rdata_o,       // Read data, next cycle
    input wire logic aux_good_a_i,              // Slot A aux good
    input wire logic main_good_a_i,             // Slot A main good
    input wire logic aux_good_b_i,              // Slot B aux good
    input wire logic main_good_b_i,             // Slot B main good
    input wire logic override_on_a_n_i,         // Slot A override, low
    input wire logic override_on_b_n_i,         // Slot B override, low
    input wire logic main_request_a_i,          // Slot A main-on pin
    input wire logic aux_request_a_i,           // Slot A aux-enable pin
    input wire logic aux_overcurrent_a_i,       // Slot A aux overcurrent
    input wire logic high_rail_overcurrent_a_i, // Slot A 12 V overcurrent
    input wire logic low_rail_overcurrent_a_i,  // Slot A 3.3 V overcurrent
    output logic main_on_a_o,                   // Slot A main outputs on
    output logic aux_on_a_o,                    // Slot A aux output on
    output logic main_on_b_o,                   // Slot B main outputs on
    output logic aux_on_b_o,                    // Slot B aux output on
    output logic power_good_out_a_n_o,          // Slot A good pin data
    output logic power_good_a_oe_n_o,           // Slot A good pin drive, low
    output logic power_good_out_b_n_o,          // Slot B good pin data
    output logic power_good_b_oe_n_o,           // Slot B good pin drive, low
    output logic fault_out_a_n_o,               // Slot A fault pin data
    output logic fault_a_oe_n_o,                // Slot A fault pin drive, low
    output logic int_n_o                        // Interrupt, active low
);
    reg_wr_if bus ();

    logic [REG_W-1:0] rdata_ff;
    logic od_low_ff;
    logic main_pend_ff;
    logic aux_pend_ff;
    logic fault_oe_n_ff;
    logic int_n_ff;

    logic [REG_W-1:0] ctrl_a_rd;
    logic [REG_W-1:0] ctrl_b_rd;
    logic [OC_W-1:0] flags_a;

    // Shared write port for both control registers and the status flags
    assign bus.wr_en = reg_wr_i;
    assign bus.addr = reg_addr_i;
    assign bus.wdata = reg_wdata_i;

    // Slot A control register
    slot_ctrl_reg #(
        .REG_ADDR(ADDR_CTRL_A)
    ) u_slot_a (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .bus(bus),
        .aux_good_i(aux_good_a_i),
        .main_good_i(main_good_a_i),
        .override_n_i(override_on_a_n_i),
        .main_req_i(main_request_a_i),
        .aux_req_i(aux_request_a_i),
        .main_trip_i(main_pend_ff),
        .aux_trip_i(aux_pend_ff),
        .ctrl_rd_o(ctrl_a_rd),
        .main_on_o(main_on_a_o),
        .aux_on_o(aux_on_a_o),
        .pg_oe_n_o(power_good_a_oe_n_o)
    );

    // Slot B has no request pins or breaker in this block
    slot_ctrl_reg #(
        .REG_ADDR(ADDR_CTRL_B)
    ) u_slot_b (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .bus(bus),
        .aux_good_i(aux_good_b_i),
        .main_good_i(main_good_b_i),
        .override_n_i(override_on_b_n_i),
        .main_req_i(1'b0),
        .aux_req_i(1'b0),
        .main_trip_i(1'b0),
        .aux_trip_i(1'b0),
        .ctrl_rd_o(ctrl_b_rd),
        .main_on_o(main_on_b_o),
        .aux_on_o(aux_on_b_o),
        .pg_oe_n_o(power_good_b_oe_n_o)
    );

    // Slot A sticky overcurrent flags
    ovc_flags #(
        .REG_ADDR(ADDR_STAT_A)
    ) u_flags_a (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .bus(bus),
        .oc_i({aux_overcurrent_a_i, high_rail_overcurrent_a_i, low_rail_overcurrent_a_i}),
        .flags_o(flags_a)
    );

    // Breaker latches: each half is held only while its request pin is high,
    // so pins tied low (register control) keep the fault inactive
    wire logic main_oc_a = high_rail_overcurrent_a_i || low_rail_overcurrent_a_i;
    wire logic nxt_main_pend = main_request_a_i && (main_pend_ff || main_oc_a);
    wire logic nxt_aux_pend = aux_request_a_i && (aux_pend_ff || aux_overcurrent_a_i);
    wire logic nxt_fault_oe_n = !(nxt_main_pend || nxt_aux_pend);
    wire logic nxt_int_n = ~|flags_a;

    // Fault latch does not look at the register port at all
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            main_pend_ff <= 1'b0;
            aux_pend_ff <= 1'b0;
            fault_oe_n_ff <= 1'b1;
        end else begin
            main_pend_ff <= nxt_main_pend;
            aux_pend_ff <= nxt_aux_pend;
            fault_oe_n_ff <= nxt_fault_oe_n;
        end
    end

    // Interrupt follows the flags, dropping a cycle after the last clear
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            int_n_ff <= 1'b1;
        end else begin
            int_n_ff <= nxt_int_n;
        end
    end

    // Status readback; fault bit reflects the pin as driven
    wire logic [REG_W-1:0] stat_a_rd = {
        !fault_oe_n_ff,
        main_on_a_o,
        aux_on_a_o,
        flags_a[OC_AUX],
        STAT_RSV_ZERO,
        flags_a[OC_HIGH],
        STAT_RSV_ZERO,
        flags_a[OC_LOW]
    };

    // Read selection; unknown commands read as zero
    wire logic sel_ctrl_a = (reg_addr_i == ADDR_CTRL_A);
    wire logic sel_ctrl_b = (reg_addr_i == ADDR_CTRL_B);
    wire logic sel_stat_a = (reg_addr_i == ADDR_STAT_A);
    wire logic [REG_W-1:0] rd_mux = sel_ctrl_a ? ctrl_a_rd :
                                    sel_ctrl_b ? ctrl_b_rd :
                                    sel_stat_a ? stat_a_rd : RD_UNMAPPED;

    // Read data held until the next read
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rdata_ff <= REG_RESET;
        end else if (reg_rd_i) begin
            rdata_ff <= rd_mux;
        end
    end

    // Open-drain pins only ever pull low
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            od_low_ff <= 1'b0;
        end else begin
            od_low_ff <= 1'b0;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign power_good_out_a_n_o = od_low_ff;
    assign power_good_out_b_n_o = od_low_ff;
    assign fault_out_a_n_o = od_low_ff;
    assign fault_a_oe_n_o = fault_oe_n_ff;
    assign int_n_o = int_n_ff;

    // Checks on this block's outputs and its internal flag state
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    property p_aux_good_rd;
        (reg_rd_i && sel_ctrl_a) |=> (reg_rdata_o[CTRL_AUX_GOOD_BIT] == $past(aux_good_a_i));
    endproperty
    a_aux_good_rd: assert property (p_aux_good_rd) else $error("aux good bit wrong");

    property p_main_good_rd;
        (reg_rd_i && sel_ctrl_a && !override_on_a_n_i) |=>
            (reg_rdata_o[CTRL_MAIN_GOOD_BIT] == $past(main_good_a_i));
    endproperty
    a_main_good_rd: assert property (p_main_good_rd) else $error("main good bit wrong");

    property p_rsv_zero;
        (reg_rd_i && (sel_ctrl_a || sel_ctrl_b)) |=>
            (reg_rdata_o[CTRL_RSV_MSB:CTRL_RSV_LSB] == CTRL_RSV_ZERO);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits not zero");

    property p_force_pg;
        (!override_on_a_n_i && !ctrl_a_rd[CTRL_GATE_BIT]) |=> power_good_a_oe_n_o;
    endproperty
    a_force_pg: assert property (p_force_pg) else $error("override did not release");

    property p_gate_blocks;
        (override_on_a_n_i == 1'b0 && ctrl_a_rd[CTRL_GATE_BIT] && aux_good_a_i && main_good_a_i)
            |=> !power_good_a_oe_n_o;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("gate did not block");

    property p_main_en;
        (reg_wr_i && sel_ctrl_a && reg_wdata_i[CTRL_MAIN_EN_BIT]) |-> ##2 main_on_a_o;
    endproperty
    a_main_en: assert property (p_main_en) else $error("main not switched on");

    property p_aux_en;
        (reg_wr_i && sel_ctrl_a && reg_wdata_i[CTRL_AUX_EN_BIT]) |-> ##2 aux_on_a_o;
    endproperty
    a_aux_en: assert property (p_aux_en) else $error("aux not switched on");

    property p_reset_off;
        @(posedge clk_sys_i) disable iff (1'b0)
        !nrst_i |=> (!main_on_a_o && !aux_on_a_o && !main_on_b_o && !aux_on_b_o && int_n_o);
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("outputs not off in reset");

    property p_pg_and;
        (override_on_a_n_i && aux_good_a_i && main_good_a_i) |=> !power_good_a_oe_n_o;
    endproperty
    a_pg_and: assert property (p_pg_and) else $error("power good not driven");

    property p_pg_b;
        (override_on_b_n_i && aux_good_b_i && main_good_b_i) ##1 !aux_good_b_i
            |=> power_good_b_oe_n_o;
    endproperty
    a_pg_b: assert property (p_pg_b) else $error("slot B good wrong");

    property p_fault_bit;
        (reg_rd_i && sel_stat_a) |=> (reg_rdata_o[STAT_FAULT_BIT] == !$past(fault_a_oe_n_o));
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("fault bit mismatch");

    property p_oc_set;
        high_rail_overcurrent_a_i |=> flags_a[OC_HIGH] ##1 !int_n_o;
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("overcurrent flag lost");

    property p_w1c;
        (reg_wr_i && sel_stat_a && reg_wdata_i[STAT_LOW_OC_BIT] && !low_rail_overcurrent_a_i)
            |=> !flags_a[OC_LOW];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");

    property p_fault_release;
        (!main_request_a_i && !aux_request_a_i) |=> fault_a_oe_n_o;
    endproperty
    a_fault_release: assert property (p_fault_release) else $error("fault held");

    property p_fault_hold;
        (main_request_a_i && !fault_a_oe_n_o && !aux_pend_ff) |=> !fault_a_oe_n_o;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early");

    property p_stat_on;
        (reg_rd_i && sel_stat_a) |=> (reg_rdata_o[STAT_MAIN_ON_BIT] == $past(main_on_a_o)) &&
            (reg_rdata_o[STAT_AUX_ON_BIT] == $past(aux_on_a_o));
    endproperty
    a_stat_on: assert property (p_stat_on) else $error("on state bits wrong");

    property p_fault_keep;
        (main_pend_ff && main_request_a_i && (reg_rd_i || reg_wr_i)) |=> !fault_a_oe_n_o;
    endproperty
    a_fault_keep: assert property (p_fault_keep) else $error("access moved fault pin");

    // A zero written over a set flag must not clear it
    property p_flag_keep;
        (reg_wr_i && sel_stat_a && !reg_wdata_i[STAT_HIGH_OC_BIT] && flags_a[OC_HIGH])
            |=> flags_a[OC_HIGH];
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag cleared by zero");

    cov_flag_set: cover property (aux_overcurrent_a_i ##1 (!int_n_o)[*2]);
    cov_gate_hold: cover property (!override_on_a_n_i && ctrl_a_rd[CTRL_GATE_BIT] ##1 !power_good_a_oe_n_o);
    cov_flag_clr: cover property (!int_n_o ##1 (reg_wr_i && sel_stat_a) ##2 int_n_o);
    cov_fault: cover property (main_request_a_i && main_oc_a ##1 !fault_a_oe_n_o);
    cov_forced: cover property (!override_on_a_n_i && aux_good_a_i && main_good_a_i);
endmodule // slot_power_control_status_regs
